// *** rtl/scg_pkg.sv ***
// constants, field layouts and bus carriers of the system clock generator.
// assumes a single 25 MHz clock that stands for the selected system clock.
package scg_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ       = 25;
	localparam int HOLD_MIN_NS   = 277000;
	localparam int HOLD_MAX_NS   = 1075000;
	// least time rounds up, longest time rounds down
	localparam int HOLD_MIN_CYC  = (HOLD_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int HOLD_MAX_CYC  = (HOLD_MAX_NS * CLK_MHZ) / 1000;
	localparam int SETTLE_EXP_0  = 10;
	localparam int SETTLE_EXP_1  = 12;
	localparam int SETTLE_EXP_2  = 15;
	localparam int SETTLE_EXP_3  = 17;
	localparam int SETTLE_CYC_0  = 1 << SETTLE_EXP_0;
	localparam int SETTLE_CYC_1  = 1 << SETTLE_EXP_1;
	localparam int SETTLE_CYC_2  = 1 << SETTLE_EXP_2;
	localparam int SETTLE_CYC_3  = 1 << SETTLE_EXP_3;
	localparam int CNT_W         = 18;

	// ------------------------------------------------------------
	// register map: printed offsets are indices, byte address = 4x
	// ------------------------------------------------------------
	localparam int ADDR_W        = 18;
	localparam int IDX_SETTLE    = 16'hFFF4;
	localparam int IDX_CPU_DIV   = 16'hFFFB;
	localparam int IDX_PER_DIV   = 16'hFFF3;
	localparam int IDX_STATUS    = 16'hFFF0;
	localparam logic [ADDR_W-1:0] ADDR_SETTLE  = ADDR_W'(IDX_SETTLE * 4);
	localparam logic [ADDR_W-1:0] ADDR_CPU_DIV = ADDR_W'(IDX_CPU_DIV * 4);
	localparam logic [ADDR_W-1:0] ADDR_PER_DIV = ADDR_W'(IDX_PER_DIV * 4);
	localparam logic [ADDR_W-1:0] ADDR_STATUS  = ADDR_W'(IDX_STATUS * 4);
	localparam logic [7:0] CPU_DIV_RST = 8'h02;
	localparam logic [7:0] PER_DIV_RST = 8'h02;
	localparam logic [7:0] SETTLE_RST  = 8'h00;
	localparam int CPU_DIV_BIT    = 1;
	localparam int STAT_RUN_BIT   = 0;
	localparam int STAT_SETTLE_BIT = 1;
	localparam int STAT_STOP_BIT  = 2;
	localparam int STAT_SRC_LSB   = 3;

	// ------------------------------------------------------------
	// configuration byte layout and clock sources
	// ------------------------------------------------------------
	localparam int OPT_SRC_LSB  = 0;
	localparam int OPT_WAIT_LSB = 2;
	localparam logic [1:0] SRC_INTERNAL  = 2'h0;
	localparam logic [1:0] SRC_RESONATOR = 2'h1;
	localparam logic [1:0] SRC_EXTERNAL  = 2'h2;
	localparam logic [1:0] PER_DIV_BAD   = 2'h3;
	localparam logic [1:0] RESP_OKAY     = 2'h0;
	localparam logic [1:0] RESP_SLVERR   = 2'h2;

	typedef struct packed {
		logic              awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic              wvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [ADDR_W-1:0] araddr;
		logic              rready;
	} scg_axi_req_type;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} scg_axi_rsp_type;

endpackage

// *** rtl/scg_top.sv ***
// system clock generator: source choice from the configuration byte,
// start-up hold, stabilization waits, prescaler and pin allocation.
// assumes ref_clk stands for the selected system clock and that the
// configuration byte is stable, on this clock, from reset onward.
//
// What this block does
// - settle code 00/01/10/11 waits 2^10/2^12/2^15/2^17 system clocks.
// - post-stop wait counting starts only once the oscillator is running.
// - wait after reset comes from the configuration byte, not software.
// - wait after leaving stop comes from the software settle register.
// - internal oscillator frees both oscillator pins as ports.
// - resonator selection dedicates both oscillator pins to the resonator.
// - external clock drives the input pin; output pin becomes a port.
// - prescaler divides system clock for peripherals, then again for cpu.
// - internal oscillator releases the cpu without any stabilization wait.
// - configuration byte is read after reset, then the source chosen.
// - operation held 277 us to 1.075 ms after reset release.
// - resonator start runs internal oscillator first, then switches.
// - resonator clock reaches the cpu only after its configured wait.
// - internal or external source applies no stabilization wait.
// - cpu and peripheral divider registers reset to 02H.
// - peripheral divider 00/01/10 gives fx, fx/2, fx/4; 11 prohibited.
`timescale 1ns/1ps
`default_nettype none

module scg_top
	import scg_pkg::*;
#(
	parameter int HOLD_CYCLES = scg_pkg::HOLD_MIN_CYC,
	parameter int SETTLE_C0   = scg_pkg::SETTLE_CYC_0,
	parameter int SETTLE_C1   = scg_pkg::SETTLE_CYC_1,
	parameter int SETTLE_C2   = scg_pkg::SETTLE_CYC_2,
	parameter int SETTLE_C3   = scg_pkg::SETTLE_CYC_3
) (
	input  wire logic                     ref_clk,
	input  wire logic                     rst,
	input  wire scg_pkg::scg_axi_req_type axi_req,
	output var  scg_pkg::scg_axi_rsp_type axi_rsp,
	input  wire logic [7:0]               option_byte,
	input  wire logic                     osc_started,
	input  wire logic                     stop_req,
	input  wire logic                     wake_req,
	output logic [1:0]                    sys_src_sel,
	output logic                          resonator_en,
	output logic                          osc_in_port_en,
	output logic                          osc_out_port_en,
	output logic                          periph_clk_en,
	output logic                          cpu_clk_en,
	output logic                          cpu_released
);
	import scg_pkg::*;

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_HOLD,
		ST_OPT_READ,
		ST_OSC_WAIT,
		ST_SETTLE,
		ST_RUN,
		ST_STOP
	} scg_state_type;
	scg_state_type     state_q;
	logic [CNT_W-1:0]  cnt_q;
	logic [CNT_W-1:0]  wait_len_q;
	logic [1:0]        src_q;
	logic [7:0]        settle_q;
	logic [7:0]        cpu_div_q;
	logic [7:0]        per_div_q;
	logic              in_port_q;
	logic              out_port_q;
	logic [3:0]        div_q;
	logic              per_en_q;
	logic              cpu_en_q;
	logic              osc_s1_q;
	logic              osc_s2_q;
	logic              osc_s3_q;
	logic              osc_rise;
	logic              cnt_done;
	logic [2:0]        per_exp;
	logic [2:0]        cpu_exp;
	logic [3:0]        per_mask;
	logic [3:0]        cpu_mask;
	logic              aw_have_q;
	logic              w_have_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [7:0]        w_byte_q;
	logic              w_lane_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;
	logic              rvalid_q;
	logic [31:0]       rdata_q;
	logic [1:0]        rresp_q;
	logic              wr_fire;
	logic              wr_hit;
	logic [7:0]        status;
	function automatic logic [CNT_W-1:0] settle_len(input logic [1:0] code);
		case (code)
			2'h0:    settle_len = CNT_W'(SETTLE_C0);
			2'h1:    settle_len = CNT_W'(SETTLE_C1);
			2'h2:    settle_len = CNT_W'(SETTLE_C2);
			default: settle_len = CNT_W'(SETTLE_C3);
		endcase
	endfunction
	function automatic logic [3:0] exp_mask(input logic [2:0] e);
		case (e)
			3'h0:    exp_mask = 4'h0;
			3'h1:    exp_mask = 4'h1;
			3'h2:    exp_mask = 4'h3;
			3'h3:    exp_mask = 4'h7;
			default: exp_mask = 4'hF;
		endcase
	endfunction
	// ------------------------------------------------------------
	// oscillator start detection
	// ------------------------------------------------------------
	// the third stage only feeds the edge detector
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			osc_s1_q <= 1'b0;
			osc_s2_q <= 1'b0;
			osc_s3_q <= 1'b0;
		end else begin
			osc_s1_q <= osc_started;
			osc_s2_q <= osc_s1_q;
			osc_s3_q <= osc_s2_q;
		end
	end
	// an edge, not a level: a high left over from before stop starts nothing
	assign osc_rise = osc_s2_q & ~osc_s3_q;
	assign cnt_done = (cnt_q == wait_len_q - CNT_W'(1));

	// ------------------------------------------------------------
	// start-up and stop sequencing
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q    <= ST_HOLD;
			cnt_q      <= '0;
			wait_len_q <= CNT_W'(HOLD_CYCLES);
		end else begin
			case (state_q)
				ST_HOLD: begin
					cnt_q <= cnt_q + CNT_W'(1);
					if (cnt_done) begin
						state_q <= ST_OPT_READ;
					end
				end
				ST_OPT_READ: begin
					cnt_q <= '0;
					if (option_byte[OPT_SRC_LSB +: 2] == SRC_RESONATOR) begin
						state_q <= ST_OSC_WAIT;
					end else begin
						state_q <= ST_RUN;
					end
					wait_len_q <= settle_len(option_byte[OPT_WAIT_LSB +: 2]);
				end
				ST_OSC_WAIT: begin
					cnt_q <= '0;
					if (osc_rise) begin
						state_q <= ST_SETTLE;
					end
				end
				ST_SETTLE: begin
					cnt_q <= cnt_q + CNT_W'(1);
					if (cnt_done) begin
						state_q <= ST_RUN;
					end
				end
				ST_RUN: begin
					cnt_q <= '0;
					if (stop_req) begin
						state_q <= ST_STOP;
					end
				end
				ST_STOP: begin
					cnt_q <= '0;
					if (wake_req) begin
						if (src_q == SRC_RESONATOR) begin
							// software is trusted to cover the resonator
							wait_len_q <= settle_len(settle_q[1:0]);
							state_q    <= ST_OSC_WAIT;
						end else begin
							state_q <= ST_RUN;
						end
					end
				end
				default: begin
					state_q <= ST_HOLD;
					cnt_q   <= '0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// source choice and pin allocation
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			src_q      <= SRC_INTERNAL;
			in_port_q  <= 1'b0;
			out_port_q <= 1'b0;
		end else if (state_q == ST_OPT_READ) begin
			// the undefined source code falls back to the internal oscillator
			case (option_byte[OPT_SRC_LSB +: 2])
				SRC_RESONATOR: begin
					src_q      <= SRC_RESONATOR;
					in_port_q  <= 1'b0;
					out_port_q <= 1'b0;
				end
				SRC_EXTERNAL: begin
					src_q      <= SRC_EXTERNAL;
					in_port_q  <= 1'b0;
					out_port_q <= 1'b1;
				end
				default: begin
					src_q      <= SRC_INTERNAL;
					in_port_q  <= 1'b1;
					out_port_q <= 1'b1;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// prescaler
	// ------------------------------------------------------------
	// the prohibited divider code is run as fx/4 rather than left undefined
	assign per_exp  = (per_div_q[1:0] == PER_DIV_BAD) ? 3'h2 :
			{1'b0, per_div_q[1:0]};
	assign cpu_exp  = per_exp + (cpu_div_q[CPU_DIV_BIT] ? 3'h2 : 3'h0);
	assign per_mask = exp_mask(per_exp);
	assign cpu_mask = exp_mask(cpu_exp);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			div_q    <= 4'h0;
			per_en_q <= 1'b0;
			cpu_en_q <= 1'b0;
		end else if (state_q == ST_RUN) begin
			div_q    <= div_q + 4'h1;
			per_en_q <= ((div_q & per_mask) == 4'h0);
			cpu_en_q <= ((div_q & cpu_mask) == 4'h0);
		end else begin
			div_q    <= 4'h0;
			per_en_q <= 1'b0;
			cpu_en_q <= 1'b0;
		end
	end

	assign sys_src_sel     = src_q;
	assign resonator_en    = (src_q == SRC_RESONATOR) && (state_q != ST_STOP);
	assign osc_in_port_en  = in_port_q;
	assign osc_out_port_en = out_port_q;
	assign periph_clk_en   = per_en_q;
	assign cpu_clk_en      = cpu_en_q;
	assign cpu_released    = (state_q == ST_RUN);

	// ------------------------------------------------------------
	// register bus: write path
	// ------------------------------------------------------------
	assign wr_fire = aw_have_q & w_have_q & ~bvalid_q;
	assign wr_hit  = (aw_addr_q == ADDR_SETTLE) ||
			(aw_addr_q == ADDR_CPU_DIV) || (aw_addr_q == ADDR_PER_DIV) ||
			(aw_addr_q == ADDR_STATUS);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			aw_addr_q <= '0;
			w_byte_q  <= 8'h00;
			w_lane_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
		end else begin
			if (axi_req.awvalid && !aw_have_q && !bvalid_q) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= axi_req.awaddr;
			end
			if (axi_req.wvalid && !w_have_q && !bvalid_q) begin
				w_have_q <= 1'b1;
				w_byte_q <= axi_req.wdata[7:0];
				w_lane_q <= axi_req.wstrb[0];
			end
			if (wr_fire) begin
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && axi_req.bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// status is read-only; a write to it is accepted and has no effect
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			settle_q  <= SETTLE_RST;
			cpu_div_q <= CPU_DIV_RST;
			per_div_q <= PER_DIV_RST;
		end else if (wr_fire && w_lane_q) begin
			if (aw_addr_q == ADDR_SETTLE) begin
				settle_q <= {6'h00, w_byte_q[1:0]};
			end
			if (aw_addr_q == ADDR_CPU_DIV) begin
				cpu_div_q <= w_byte_q & CPU_DIV_RST;
			end
			if (aw_addr_q == ADDR_PER_DIV) begin
				per_div_q <= {6'h00, w_byte_q[1:0]};
			end
		end
	end

	// ------------------------------------------------------------
	// register bus: read path
	// ------------------------------------------------------------
	always_comb begin
		status = 8'h00;
		status[STAT_RUN_BIT]    = (state_q == ST_RUN);
		status[STAT_SETTLE_BIT] = (state_q == ST_SETTLE) ||
				(state_q == ST_OSC_WAIT);
		status[STAT_STOP_BIT]   = (state_q == ST_STOP);
		status[STAT_SRC_LSB +: 2] = src_q;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= RESP_OKAY;
		end else if (axi_req.arvalid && !rvalid_q) begin
			rvalid_q <= 1'b1;
			rresp_q  <= RESP_OKAY;
			case (axi_req.araddr)
				ADDR_SETTLE:  rdata_q <= {24'h000000, settle_q};
				ADDR_CPU_DIV: rdata_q <= {24'h000000, cpu_div_q};
				ADDR_PER_DIV: rdata_q <= {24'h000000, per_div_q};
				ADDR_STATUS:  rdata_q <= {24'h000000, status};
				default: begin
					rdata_q <= 32'h0000_0000;
					rresp_q <= RESP_SLVERR;
				end
			endcase
		end else if (rvalid_q && axi_req.rready) begin
			rvalid_q <= 1'b0;
		end
	end

	always_comb begin
		axi_rsp         = '0;
		axi_rsp.awready = ~aw_have_q & ~bvalid_q;
		axi_rsp.wready  = ~w_have_q & ~bvalid_q;
		axi_rsp.bvalid  = bvalid_q;
		axi_rsp.bresp   = bresp_q;
		axi_rsp.arready = ~rvalid_q;
		axi_rsp.rvalid  = rvalid_q;
		axi_rsp.rdata   = rdata_q;
		axi_rsp.rresp   = rresp_q;
	end

endmodule
`default_nettype wire

// *** test/scg_properties.sv ***
// port checker of the system clock generator.
// assumes it is bound to scg_top and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module scg_properties
	import scg_pkg::*;
(
	input wire logic                     ref_clk,
	input wire logic                     rst,
	input wire scg_pkg::scg_axi_req_type axi_req,
	input wire scg_pkg::scg_axi_rsp_type axi_rsp,
	input wire logic                     stop_req,
	input wire logic [1:0]               sys_src_sel,
	input wire logic                     resonator_en,
	input wire logic                     osc_in_port_en,
	input wire logic                     osc_out_port_en,
	input wire logic                     cpu_clk_en,
	input wire logic                     cpu_released
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	// ------------------------------------------------------------
	// clock gating and pins
	// ------------------------------------------------------------
	property p_stop_halts;
		cpu_released && stop_req |=> !cpu_released;
	endproperty
	a_stop_halts: assert property (p_stop_halts)
		else $error("cpu still released after stop");
	// one cycle of slack: the enable is a flop behind the state
	property p_gate_held;
		!cpu_released && !$past(cpu_released) |-> !cpu_clk_en;
	endproperty
	a_gate_held: assert property (p_gate_held)
		else $error("cpu clock enable while held");
	property p_int_pins;
		cpu_released && sys_src_sel == SRC_INTERNAL
			|-> osc_in_port_en && osc_out_port_en;
	endproperty
	a_int_pins: assert property (p_int_pins)
		else $error("internal source left a pin unfreed");
	property p_res_pins;
		cpu_released && sys_src_sel == SRC_RESONATOR
			|-> !osc_in_port_en && !osc_out_port_en;
	endproperty
	a_res_pins: assert property (p_res_pins)
		else $error("resonator pin freed as port");
	property p_ext_pins;
		cpu_released && sys_src_sel == SRC_EXTERNAL
			|-> !osc_in_port_en && osc_out_port_en;
	endproperty
	a_ext_pins: assert property (p_ext_pins)
		else $error("external clock pin allocation wrong");
	property p_res_only;
		resonator_en |-> sys_src_sel == SRC_RESONATOR &&
			!osc_in_port_en && !osc_out_port_en;
	endproperty
	a_res_only: assert property (p_res_only)
		else $error("resonator enabled for another source");
	// the cpu was held with the resonator running well before release
	property p_res_settled;
		$rose(cpu_released) && sys_src_sel == SRC_RESONATOR
			|-> $past(resonator_en && !cpu_released, 4);
	endproperty
	a_res_settled: assert property (p_res_settled)
		else $error("resonator clock released before its wait");

	// ------------------------------------------------------------
	// register bus
	// ------------------------------------------------------------
	property p_b_stands;
		axi_rsp.bvalid && !axi_req.bready
			|=> axi_rsp.bvalid && $stable(axi_rsp.bresp);
	endproperty
	a_b_stands: assert property (p_b_stands)
		else $error("write response dropped early");
	property p_r_stands;
		axi_rsp.rvalid && !axi_req.rready
			|=> axi_rsp.rvalid && $stable(axi_rsp.rdata);
	endproperty
	a_r_stands: assert property (p_r_stands)
		else $error("read data dropped early");
endmodule
`default_nettype wire

// *** test/scg_osc_model.sv ***
// resonator model: starts oscillating a fixed time after it is enabled.
// assumes resonator_en from the block; no oscillation while disabled.
`timescale 1ns/1ps
`default_nettype none
module scg_osc_model #(
	parameter int START_CYC = 10
) (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic resonator_en,
	output var  logic osc_started
);
	int cnt_q;
	// a powered-down resonator stops at once, so each start counts afresh
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_q       <= 0;
			osc_started <= 1'b0;
		end else if (!resonator_en) begin
			cnt_q       <= 0;
			osc_started <= 1'b0;
		end else if (cnt_q == START_CYC - 1) begin
			osc_started <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 1;
		end
	end
endmodule
`default_nettype wire

// *** test/testbench.sv ***
// self-checking bench of the system clock generator.
// assumes short hold and settle counts and the resonator model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import scg_pkg::*;
	localparam int HOLD = 20;
	localparam int DLY  = 10;
	localparam logic [7:0] RUN_INT = 8'(1 << STAT_RUN_BIT);
	localparam logic [7:0] RUN_EXT =
		RUN_INT | 8'(int'(SRC_EXTERNAL) << STAT_SRC_LSB);
	logic            ref_clk  = 1'b0;
	logic            rst      = 1'b1;
	scg_axi_req_type req      = '0;
	scg_axi_rsp_type rsp;
	logic [7:0]      opt      = 8'h00;
	logic            stop_req = 1'b0;
	logic            wake_req = 1'b0;
	logic            osc_started;
	logic [1:0]      src;
	logic            res_en;
	logic            in_pe;
	logic            out_pe;
	logic            per_en;
	logic            cpu_en;
	logic            cpu_released;
	int              fail_count = 0;
	int              num_checks = 0;
	logic [31:0]     d;
	logic [1:0]      r;
	int              n;

	always #20 ref_clk = ~ref_clk;

	scg_top #(.HOLD_CYCLES(HOLD), .SETTLE_C0(4), .SETTLE_C1(8),
		.SETTLE_C2(16), .SETTLE_C3(32)) u_scg_top (
		.ref_clk(ref_clk), .rst(rst), .axi_req(req), .axi_rsp(rsp),
		.option_byte(opt), .osc_started(osc_started),
		.stop_req(stop_req), .wake_req(wake_req), .sys_src_sel(src),
		.resonator_en(res_en), .osc_in_port_en(in_pe),
		.osc_out_port_en(out_pe), .periph_clk_en(per_en),
		.cpu_clk_en(cpu_en), .cpu_released(cpu_released));
	scg_osc_model #(.START_CYC(DLY)) u_osc (.ref_clk(ref_clk),
		.rst(rst), .resonator_en(res_en), .osc_started(osc_started));

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic tmo(input int k);
		if (k >= 3000) begin
			chk("wait", 0, 1);
			summarize();
		end
	endtask
	// readies come from flops, so a look just after an edge tells what
	// the next edge takes
	task automatic wr(input logic [17:0] a, input logic [31:0] v);
		int k;
		logic ah, wh, bh;
		@(posedge ref_clk);
		req.awvalid <= 1'b1;
		req.awaddr  <= a;
		req.wvalid  <= 1'b1;
		req.wdata   <= v;
		req.wstrb   <= 4'hF;
		req.bready  <= 1'b1;
		k = 0;
		do begin
			#1;
			ah = req.awvalid && rsp.awready;
			wh = req.wvalid && rsp.wready;
			bh = rsp.bvalid;
			@(posedge ref_clk);
			if (ah) req.awvalid <= 1'b0;
			if (wh) req.wvalid <= 1'b0;
			k++;
		end while (!bh && k < 3000);
		req.bready <= 1'b0;
		tmo(k);
	endtask
	task automatic rd(input logic [17:0] a);
		int k;
		logic ah, vh;
		@(posedge ref_clk);
		req.arvalid <= 1'b1;
		req.araddr  <= a;
		req.rready  <= 1'b1;
		k = 0;
		do begin
			#1;
			ah = req.arvalid && rsp.arready;
			vh = rsp.rvalid;
			d  = rsp.rdata;
			r  = rsp.rresp;
			@(posedge ref_clk);
			if (ah) req.arvalid <= 1'b0;
			k++;
		end while (!vh && k < 3000);
		req.rready <= 1'b0;
		tmo(k);
	endtask
	task automatic wait_rel;
		n = 0;
		do begin
			@(posedge ref_clk);
			wake_req <= 1'b0;
			#1;
			n++;
		end while (!cpu_released && n < 3000);
		tmo(n);
	endtask
	task automatic boot(input logic [7:0] o);
		@(posedge ref_clk);
		rst <= 1'b1;
		opt <= o;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		wait_rel();
	endtask
	task automatic stopwake;
		@(posedge ref_clk);
		stop_req <= 1'b1;
		@(posedge ref_clk);
		stop_req <= 1'b0;
		#1 chk("stopped", 0, cpu_released);
		@(posedge ref_clk);
		wake_req <= 1'b1;
		wait_rel();
	endtask
	task automatic gap(input bit c);
		int k;
		k = 0;
		do begin
			@(posedge ref_clk);
			#1;
			k++;
		end while (!(c ? cpu_en : per_en) && k < 100);
		n = 0;
		do begin
			@(posedge ref_clk);
			#1;
			n++;
		end while (!(c ? cpu_en : per_en) && n < 100);
	endtask

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		boot(8'h00);
		chk("int release", HOLD + 1, n);
		chk("int pins", 2'b11, {in_pe, out_pe});
		rd(ADDR_STATUS);
		chk("int status", RUN_INT, d);
		rd(ADDR_CPU_DIV);
		chk("cpu div", 8'h02, d);
		rd(ADDR_PER_DIV);
		chk("per div", 8'h02, d);
		gap(1);
		gap(1);
		chk("cpu gap", 16, n);
		for (int c = 0; c < 3; c++) begin
			wr(ADDR_PER_DIV, c);
			gap(0);
			gap(0);
			chk("per gap", 1 << c, n);
		end
		// only the divider bit is writable; with it clear the cpu runs at
		// the peripheral rate, fx/4 here
		wr(ADDR_CPU_DIV, 32'hFF);
		rd(ADDR_CPU_DIV);
		chk("cpu div mask", 8'h02, d);
		wr(ADDR_CPU_DIV, 32'h0);
		gap(1);
		gap(1);
		chk("cpu gap same", 4, n);
		wr(ADDR_SETTLE, 32'hFF);
		rd(ADDR_SETTLE);
		chk("settle", 8'h03, d);
		rd(ADDR_STATUS + 18'h4);
		chk("unmapped", 32'h0, d);
		chk("unmapped resp", RESP_SLVERR, r);
		stopwake();
		chk("int wake", 1, n);
		$display("test internal done");
		boot(8'h02);
		chk("ext release", HOLD + 1, n);
		chk("ext pins", 2'b01, {in_pe, out_pe});
		chk("ext src", SRC_EXTERNAL, src);
		rd(ADDR_STATUS);
		chk("ext status", RUN_EXT, d);
		$display("test external done");
		// power-up wait code 2 differs from the settle reset code 0
		boot(8'h09);
		chk("res boot", 1, n >= HOLD + DLY + 16 &&
			n <= HOLD + DLY + 25);
		chk("res pins", 2'b00, {in_pe, out_pe});
		chk("res src", SRC_RESONATOR, src);
		// every settle code, 4 to 32 cycles, each counted after the model's start-up;
		// the window tells neighbouring codes apart, except code 0 in the code 1 check
		for (int c = 0; c < 4; c++) begin
			wr(ADDR_SETTLE, c);
			stopwake();
			chk("res wake", 1, n >= DLY + (4 << c) &&
				n <= DLY + (4 << c) + 6);
		end
		$display("test resonator done");
		summarize();
	end
endmodule

bind scg_top scg_properties u_props (.ref_clk(ref_clk), .rst(rst),
	.axi_req(axi_req), .axi_rsp(axi_rsp), .stop_req(stop_req),
	.sys_src_sel(sys_src_sel), .resonator_en(resonator_en),
	.osc_in_port_en(osc_in_port_en), .osc_out_port_en(osc_out_port_en),
	.cpu_clk_en(cpu_clk_en), .cpu_released(cpu_released));
`default_nettype wire
